// *** bcem_regs.vh ***
// constants and summary for the bus cycle event monitor
// Summary of operation
// - An event is a combination of address, data, status and count matches, optionally with pod inputs.
// - An event can stop emulation, capture trace, count, launch a target routine and pulse a trigger.
// - Data, status and pod comparisons are sixteen bits wide.
// - With trace capture enable off the monitor detects nothing; staged writes and run restarts still apply.
// - One event may carry several actions and many statements may be active together.
// - There are four groups, each with its own statements and comparator values.
// - An action can switch the active group so ordered sequences can be detected.
// - Values written during a run are accepted but take effect only after a stop and restart.
// - Bus signals are sampled once at the end of every read or write cycle that ends while the clock enable is high, and compared there.
// - The trace record of a cycle equals what the monitor evaluated for that cycle.
// - Each group holds two address, two data, two status, one pod and one count comparator.
// - A mask bit of one excludes that bit from a data, status or pod match; zero enables it.
// - An address comparator matches a single address, inside a range or outside a range.
// - The count comparator signals when a qualifying event has occurred the programmed number of times.
`ifndef BCEM_REGS_VH
`define BCEM_REGS_VH
// address comparator modes
`define BCEM_AM_SINGLE  2'h0
`define BCEM_AM_INSIDE  2'h1
`define BCEM_AM_OUTSIDE 2'h2
`define BCEM_AM_OFF     2'h3
// comparator select inside a group (write port)
`define BCEM_SEL_AC1    4'h0
`define BCEM_SEL_AC2    4'h1
`define BCEM_SEL_DC1    4'h2
`define BCEM_SEL_DC2    4'h3
`define BCEM_SEL_ST1    4'h4
`define BCEM_SEL_ST2    4'h5
`define BCEM_SEL_POD    4'h6
`define BCEM_SEL_CNT    4'h7
`define BCEM_SEL_STMT   4'h8
// statement layout: bits 7:0 term enable per comparator, 15:8 required value,
// 16 combine (0 and, 1 or), 17 valid, 18 break, 19 trace, 20 count,
// 21 routine, 22 trigger, 23 switch, 25:24 target group
`define BCEM_ST_OR      16
`define BCEM_ST_VALID   17
`define BCEM_ST_BRK     18
`define BCEM_ST_TRC     19
`define BCEM_ST_CNT     20
`define BCEM_ST_RTN     21
`define BCEM_ST_TRG     22
`define BCEM_ST_SW      23
`define BCEM_ST_GRP_LO  24
`define BCEM_RST_VAL    24'h000000
`endif

// *** bcem_match.v ***
// masked and range comparator bank for one group
module bcem_match #(
  parameter AW = 24,
  parameter DW = 16
) (
  // sample
  input  wire [AW-1:0] s_addr,
  input  wire [DW-1:0] s_data,
  input  wire [DW-1:0] s_stat,
  input  wire [DW-1:0] s_pod,
  // comparators
  input  wire [AW-1:0] ac1_lo,
  input  wire [AW-1:0] ac1_hi,
  input  wire [1:0]    ac1_md,
  input  wire [AW-1:0] ac2_lo,
  input  wire [AW-1:0] ac2_hi,
  input  wire [1:0]    ac2_md,
  input  wire [DW-1:0] dc1_v,
  input  wire [DW-1:0] dc1_m,
  input  wire [DW-1:0] dc2_v,
  input  wire [DW-1:0] dc2_m,
  input  wire [DW-1:0] st1_v,
  input  wire [DW-1:0] st1_m,
  input  wire [DW-1:0] st2_v,
  input  wire [DW-1:0] st2_m,
  input  wire [DW-1:0] pod_v,
  input  wire [DW-1:0] pod_m,
  // results
  output wire [6:0]    hit
);
`include "bcem_regs.vh"
  function masked;
    input [DW-1:0] s;
    input [DW-1:0] v;
    input [DW-1:0] m;
    begin
      masked = (((s ^ v) & ~m) == {DW{1'b0}});
    end
  endfunction

  function amatch;
    input [AW-1:0] a;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    input [1:0]    md;
    reg            inr;
    begin
      inr = (a >= lo) && (a <= hi);
      case (md)
        `BCEM_AM_SINGLE:  amatch = (a == lo);
        `BCEM_AM_INSIDE:  amatch = inr;
        `BCEM_AM_OUTSIDE: amatch = ~inr;
        default:          amatch = 1'b0;
      endcase
    end
  endfunction

  assign hit[0] = amatch(s_addr, ac1_lo, ac1_hi, ac1_md);
  assign hit[1] = amatch(s_addr, ac2_lo, ac2_hi, ac2_md);
  assign hit[2] = masked(s_data, dc1_v, dc1_m);
  assign hit[3] = masked(s_data, dc2_v, dc2_m);
  assign hit[4] = masked(s_stat, st1_v, st1_m);
  assign hit[5] = masked(s_stat, st2_v, st2_m);
  assign hit[6] = masked(s_pod, pod_v, pod_m);
endmodule // bcem_match

// *** bcem_monitor.v ***
// bus cycle event monitor top
module bcem_monitor #(
  parameter AW = 24,
  parameter DW = 16,
  parameter NS = 4
) (
  // clock and reset
  input  wire          mclk,
  input  wire          arst_n,
  input  wire          clk_en,
  // target bus pins
  input  wire [AW-1:0] bus_addr,
  input  wire [DW-1:0] bus_data,
  input  wire [DW-1:0] bus_stat,
  input  wire          bus_cyc_end,
  input  wire [DW-1:0] logic_analyzer_pod_input,
  // control
  input  wire          trace_capture_enable,
  input  wire          run_mode,
  // firmware write port
  input  wire          cfg_we,
  input  wire [1:0]    cfg_grp,
  input  wire [3:0]    cfg_sel,
  input  wire [1:0]    cfg_idx,
  input  wire [2*AW-1:0] cfg_wdata,
  // actions
  output reg           break_req_ff,
  output reg           trace_we_ff,
  output reg [AW+3*DW-1:0] trace_data_ff,
  output reg           routine_req_ff,
  output reg           trigger_ff,
  output reg [DW-1:0]  event_count_ff,
  output reg [1:0]     active_grp_ff,
  output reg           sample_ff
);
`include "bcem_regs.vh"
  localparam SW = 26;
  // ------------------------------------------------------------
  // staged (written) and live comparator sets
  // ------------------------------------------------------------
  // staged copies absorb writes during a run; live copies only load
  // on run start, so firmware cannot disturb an evaluation in flight
  reg [2*AW-1:0] stg_ac [0:7];
  reg [1:0]      stg_am [0:7];
  reg [2*DW-1:0] stg_dc [0:31];
  reg [DW-1:0]   stg_cl [0:3];
  reg [SW-1:0]   stg_st [0:15];
  reg [2*AW-1:0] liv_ac [0:7];
  reg [1:0]      liv_am [0:7];
  reg [2*DW-1:0] liv_dc [0:31];
  reg [DW-1:0]   liv_cl [0:3];
  reg [SW-1:0]   liv_st [0:15];
  reg [DW-1:0]   occ_ff [0:3];
  integer        i;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] cyc_sy_ff;
  reg [2:0] tce_sy_ff;
  reg [2:0] run_sy_ff;
  reg       cyc_st_ff;
  reg       run_st_ff;
  reg       tce_st_ff;
  // strobe and enables settle through three flops; a level counts
  // only once the last two agree, so a runt pulse is ignored
  reg [AW-1:0] a1_ff, a2_ff, a3_ff;
  reg [DW-1:0] d1_ff, d2_ff, d3_ff;
  reg [DW-1:0] s1_ff, s2_ff, s3_ff;
  reg [DW-1:0] p1_ff, p2_ff, p3_ff;
  wire cyc_agree = (cyc_sy_ff[1] == cyc_sy_ff[2]);
  wire run_agree = (run_sy_ff[1] == run_sy_ff[2]);
  wire cyc_rise  = cyc_agree & cyc_sy_ff[2] & ~cyc_st_ff;
  wire run_rise  = run_agree & run_sy_ff[2] & ~run_st_ff;
  wire tce_on    = tce_st_ff;

  // ------------------------------------------------------------
  // sample register
  // ------------------------------------------------------------
  reg [AW-1:0] smp_a_ff;
  reg [DW-1:0] smp_d_ff;
  reg [DW-1:0] smp_s_ff;
  reg [DW-1:0] smp_p_ff;
  wire [1:0]   g = active_grp_ff;
  wire [6:0]   hit;

  bcem_match #(.AW(AW), .DW(DW)) u_match (
    .s_addr (smp_a_ff),
    .s_data (smp_d_ff),
    .s_stat (smp_s_ff),
    .s_pod  (smp_p_ff),
    .ac1_lo (liv_ac[{g,1'b0}][AW-1:0]),
    .ac1_hi (liv_ac[{g,1'b0}][2*AW-1:AW]),
    .ac1_md (liv_am[{g,1'b0}]),
    .ac2_lo (liv_ac[{g,1'b1}][AW-1:0]),
    .ac2_hi (liv_ac[{g,1'b1}][2*AW-1:AW]),
    .ac2_md (liv_am[{g,1'b1}]),
    .dc1_v  (liv_dc[{g,3'h0}][DW-1:0]),
    .dc1_m  (liv_dc[{g,3'h0}][2*DW-1:DW]),
    .dc2_v  (liv_dc[{g,3'h1}][DW-1:0]),
    .dc2_m  (liv_dc[{g,3'h1}][2*DW-1:DW]),
    .st1_v  (liv_dc[{g,3'h2}][DW-1:0]),
    .st1_m  (liv_dc[{g,3'h2}][2*DW-1:DW]),
    .st2_v  (liv_dc[{g,3'h3}][DW-1:0]),
    .st2_m  (liv_dc[{g,3'h3}][2*DW-1:DW]),
    .pod_v  (liv_dc[{g,3'h4}][DW-1:0]),
    .pod_m  (liv_dc[{g,3'h4}][2*DW-1:DW]),
    .hit    (hit)
  );

  // ------------------------------------------------------------
  // statement evaluation
  // ------------------------------------------------------------
  // a zero limit never counts as reached, so an unset group cannot fire on it
  wire       limit_hit = (occ_ff[g] >= liv_cl[g]) & (liv_cl[g] != {DW{1'b0}});
  wire [7:0] hits      = {limit_hit, hit};

  function st_fire;
    input [SW-1:0] st;
    input [7:0]    h;
    reg   [7:0]    ok;
    begin
      ok = ~(h ^ st[15:8]) & st[7:0];
      if (!st[`BCEM_ST_VALID] || st[7:0] == 8'h00)
        st_fire = 1'b0;
      else if (st[`BCEM_ST_OR])
        st_fire = (ok != 8'h00);
      else
        st_fire = (ok == st[7:0]);
    end
  endfunction

  reg [NS-1:0] fire;
  reg          a_brk, a_trc, a_cnt, a_rtn, a_trg, a_sw;
  reg [1:0]    a_grp;
  integer      k;
  always @* begin
    a_brk = 1'b0;
    a_trc = 1'b0;
    a_cnt = 1'b0;
    a_rtn = 1'b0;
    a_trg = 1'b0;
    a_sw  = 1'b0;
    a_grp = g;
    for (k = 0; k < NS; k = k + 1) begin
      fire[k] = st_fire(liv_st[g*NS+k], hits);
      if (fire[k]) begin
        a_brk = a_brk | liv_st[g*NS+k][`BCEM_ST_BRK];
        a_trc = a_trc | liv_st[g*NS+k][`BCEM_ST_TRC];
        a_cnt = a_cnt | liv_st[g*NS+k][`BCEM_ST_CNT];
        a_rtn = a_rtn | liv_st[g*NS+k][`BCEM_ST_RTN];
        a_trg = a_trg | liv_st[g*NS+k][`BCEM_ST_TRG];
        // lowest index switch wins when several statements fire
        if (liv_st[g*NS+k][`BCEM_ST_SW] && !a_sw) begin
          a_sw  = 1'b1;
          a_grp = liv_st[g*NS+k][`BCEM_ST_GRP_LO+1:`BCEM_ST_GRP_LO];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // sequential logic
  // ------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_sy_ff      <= 3'h0;
      tce_sy_ff      <= 3'h0;
      run_sy_ff      <= 3'h0;
      cyc_st_ff      <= 1'b0;
      run_st_ff      <= 1'b0;
      tce_st_ff      <= 1'b0;
      a1_ff <= {AW{1'b0}};
      a2_ff <= {AW{1'b0}};
      d1_ff <= {DW{1'b0}};
      d2_ff <= {DW{1'b0}};
      s1_ff <= {DW{1'b0}};
      s2_ff <= {DW{1'b0}};
      p1_ff <= {DW{1'b0}};
      p2_ff <= {DW{1'b0}};
      a3_ff <= {AW{1'b0}};
      d3_ff <= {DW{1'b0}};
      s3_ff <= {DW{1'b0}};
      p3_ff <= {DW{1'b0}};
      smp_a_ff       <= {AW{1'b0}};
      smp_d_ff       <= {DW{1'b0}};
      smp_s_ff       <= {DW{1'b0}};
      smp_p_ff       <= {DW{1'b0}};
      sample_ff      <= 1'b0;
      break_req_ff   <= 1'b0;
      trace_we_ff    <= 1'b0;
      trace_data_ff  <= {(AW+3*DW){1'b0}};
      routine_req_ff <= 1'b0;
      trigger_ff     <= 1'b0;
      event_count_ff <= {DW{1'b0}};
      active_grp_ff  <= 2'h0;
      for (i = 0; i < 32; i = i + 1) begin
        stg_dc[i] <= {(2*DW){1'b0}};
        liv_dc[i] <= {(2*DW){1'b0}};
      end
      for (i = 0; i < 16; i = i + 1) begin
        stg_st[i] <= {SW{1'b0}};
        liv_st[i] <= {SW{1'b0}};
      end
      for (i = 0; i < 8; i = i + 1) begin
        stg_ac[i] <= {(2*AW){1'b0}};
        liv_ac[i] <= {(2*AW){1'b0}};
        stg_am[i] <= `BCEM_AM_OFF;
        liv_am[i] <= `BCEM_AM_OFF;
      end
      for (i = 0; i < 4; i = i + 1) begin
        stg_cl[i] <= {DW{1'b0}};
        liv_cl[i] <= {DW{1'b0}};
        occ_ff[i] <= {DW{1'b0}};
      end
    end else if (clk_en) begin
      // a low clock enable holds every flop, synchronisers included
      cyc_sy_ff <= {cyc_sy_ff[1:0], bus_cyc_end};
      tce_sy_ff <= {tce_sy_ff[1:0], trace_capture_enable};
      run_sy_ff <= {run_sy_ff[1:0], run_mode};
      // bus values take three stages to line up with the strobe
      a1_ff <= bus_addr;
      a2_ff <= a1_ff;
      d1_ff <= bus_data;
      d2_ff <= d1_ff;
      s1_ff <= bus_stat;
      s2_ff <= s1_ff;
      p1_ff <= logic_analyzer_pod_input;
      p2_ff <= p1_ff;
      a3_ff <= a2_ff;
      d3_ff <= d2_ff;
      s3_ff <= s2_ff;
      p3_ff <= p2_ff;
      if (cyc_agree)
        cyc_st_ff <= cyc_sy_ff[2];
      if (run_agree)
        run_st_ff <= run_sy_ff[2];
      if (tce_sy_ff[1] == tce_sy_ff[2])
        tce_st_ff <= tce_sy_ff[2];

      // firmware writes only reach the staged set
      if (cfg_we) begin
        case (cfg_sel)
          `BCEM_SEL_AC1, `BCEM_SEL_AC2: begin
            stg_ac[{cfg_grp, cfg_sel[0]}] <= cfg_wdata;
            stg_am[{cfg_grp, cfg_sel[0]}] <= cfg_idx;
          end
          `BCEM_SEL_DC1, `BCEM_SEL_DC2, `BCEM_SEL_ST1, `BCEM_SEL_ST2, `BCEM_SEL_POD:
            stg_dc[{cfg_grp, cfg_sel[2:0] - 3'h2}] <= cfg_wdata[2*DW-1:0];
          `BCEM_SEL_CNT:
            stg_cl[cfg_grp] <= cfg_wdata[DW-1:0];
          `BCEM_SEL_STMT:
            stg_st[{cfg_grp, cfg_idx}] <= cfg_wdata[SW-1:0];
          default: ;
        endcase
      end

      // live set reloads in one clock, so a restart sees whole groups
      if (run_rise) begin
        for (i = 0; i < 32; i = i + 1)
          liv_dc[i] <= stg_dc[i];
        for (i = 0; i < 16; i = i + 1)
          liv_st[i] <= stg_st[i];
        for (i = 0; i < 8; i = i + 1) begin
          liv_ac[i] <= stg_ac[i];
          liv_am[i] <= stg_am[i];
        end
        for (i = 0; i < 4; i = i + 1) begin
          liv_cl[i] <= stg_cl[i];
          occ_ff[i] <= {DW{1'b0}};
        end
        active_grp_ff  <= 2'h0;
        event_count_ff <= {DW{1'b0}};
      end

      // one sample per cycle end, evaluated the next clock
      sample_ff <= cyc_rise & tce_on & run_st_ff;
      if (cyc_rise) begin
        smp_a_ff <= a3_ff;
        smp_d_ff <= d3_ff;
        smp_s_ff <= s3_ff;
        smp_p_ff <= p3_ff;
      end

      // action pulses default low so each stands exactly one enabled clock
      break_req_ff   <= 1'b0;
      trace_we_ff    <= 1'b0;
      routine_req_ff <= 1'b0;
      trigger_ff     <= 1'b0;
      // a run restart wins over a pending sample, which is dropped
      if (sample_ff && tce_on && !run_rise) begin
        break_req_ff   <= a_brk;
        trace_we_ff    <= a_trc;
        trace_data_ff  <= {smp_p_ff, smp_s_ff, smp_d_ff, smp_a_ff};
        routine_req_ff <= a_rtn;
        trigger_ff     <= a_trg;
        if (a_cnt) begin
          event_count_ff <= event_count_ff + {{(DW-1){1'b0}}, 1'b1};
          occ_ff[g]      <= occ_ff[g] + {{(DW-1){1'b0}}, 1'b1};
        end
        // the new group's comparators apply from the next sample
        active_grp_ff <= a_grp;
      end
    end
  end
endmodule // bcem_monitor

// *** bcem_monitor_checker.sv ***
// assertion checker bound to the bus cycle event monitor
module bcem_monitor_checker #(
  parameter AW = 24,
  parameter DW = 16
) (
  // clock and reset
  input logic               mclk,
  input logic               arst_n,
  input logic               clk_en,
  // sampled pins
  input logic [AW-1:0]      bus_addr,
  input logic [DW-1:0]      bus_data,
  input logic [DW-1:0]      bus_stat,
  input logic [DW-1:0]      logic_analyzer_pod_input,
  // actions
  input logic               break_req_ff,
  input logic               trace_we_ff,
  input logic [AW+3*DW-1:0] trace_data_ff,
  input logic               routine_req_ff,
  input logic               trigger_ff,
  input logic [DW-1:0]      event_count_ff,
  input logic [1:0]         active_grp_ff,
  input logic               sample_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ----
  // actions follow their own sample
  // ----
  a_brk_rtn_follow: assert property ((break_req_ff || routine_req_ff) |-> $past(sample_ff))
    else $error("break or routine pulse without a sample");
  a_trace_follow: assert property (trace_we_ff |-> $past(sample_ff))
    else $error("trace write without a sample");
  a_trig_follow: assert property ($rose(trigger_ff) |-> $past(sample_ff))
    else $error("trigger without a sample");
  a_trig_pulse: assert property (trigger_ff && clk_en |=> !trigger_ff)
    else $error("trigger longer than one cycle");
  a_sample_once: assert property (sample_ff && clk_en |=> !sample_ff)
    else $error("one bus cycle sampled twice");
  a_freeze_hold: assert property (!clk_en |=> $stable(event_count_ff) && $stable(active_grp_ff)
    && $stable(sample_ff) && $stable(trace_data_ff))
    else $error("state moved while the clock enable was low");
  a_trace_record: assert property (trace_we_ff |-> trace_data_ff ==
    {logic_analyzer_pod_input, bus_stat, bus_data, bus_addr})
    else $error("trace record differs from sampled pins");
  a_grp_source: assert property ($changed(active_grp_ff) && active_grp_ff != 2'h0
    |-> $past(sample_ff))
    else $error("group switched without a sample");
  a_count_step: assert property ($changed(event_count_ff) && event_count_ff != '0
    |-> $past(sample_ff) && event_count_ff == $past(event_count_ff) + 1'b1)
    else $error("event count moved by other than one");
endmodule // bcem_monitor_checker

bind bcem_monitor bcem_monitor_checker #(.AW(AW), .DW(DW)) i_chk (.*);

// *** bcem_target_model.sv ***
// behavioural target processor bus and analyzer pod
module bcem_target_model #(
  parameter AW = 24,
  parameter DW = 16
) (
  // clock
  input  logic          mclk,
  // bus and pod pins
  output logic [AW-1:0] bus_addr,
  output logic [DW-1:0] bus_data,
  output logic [DW-1:0] bus_stat,
  output logic [DW-1:0] logic_analyzer_pod_input,
  output logic          bus_cyc_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {bus_addr, bus_data, bus_stat, logic_analyzer_pod_input} = '0;
    bus_cyc_end = 1'b0;
  end
  // ----
  // one read or write cycle, slow adds settle cycles
  // ----
  task automatic cycle(input logic [AW-1:0] a, input logic [DW-1:0] d, s, p, input int slow);
    @(negedge mclk);
    {bus_addr, bus_data, bus_stat, logic_analyzer_pod_input} = {a, d, s, p};
    repeat (2 + slow) @(negedge mclk);
    bus_cyc_end = 1'b1;
    repeat (3) @(negedge mclk);
    bus_cyc_end = 1'b0;
    repeat (6) @(negedge mclk);
    // released bus: inverse so a stale value never passes for a match
    {bus_addr, bus_data, bus_stat, logic_analyzer_pod_input} = ~{a, d, s, p};
  endtask
endmodule // bcem_target_model

// *** test_bus_cycle_event_monitor.sv ***
// self-checking bench for the bus cycle event monitor
`include "bcem_regs.vh"
module test_bus_cycle_event_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        arst_n;
  logic        clk_en;
  logic        trace_capture_enable;
  logic        run_mode;
  logic        cfg_we;
  logic [1:0]  cfg_grp;
  logic [3:0]  cfg_sel;
  logic [1:0]  cfg_idx;
  logic [47:0] cfg_wdata;
  logic [23:0] bus_addr;
  logic [15:0] bus_data;
  logic [15:0] bus_stat;
  logic [15:0] logic_analyzer_pod_input;
  logic        bus_cyc_end;
  logic        break_req_ff;
  logic        trace_we_ff;
  logic [71:0] trace_data_ff;
  logic        routine_req_ff;
  logic        trigger_ff;
  logic [15:0] event_count_ff;
  logic [1:0]  active_grp_ff;
  logic        sample_ff;
  int          miscompares = 0;
  int          check_count = 0;

  bcem_monitor i_dut (.*);
  bcem_target_model i_tgt (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ----
  // helpers
  // ----
  function automatic logic [15:0] rnd();
    return 16'($urandom);
  endfunction
  function automatic logic fn_addr(input logic [1:0] md, input logic [23:0] lo, hi, a);
    case (md)
      2'h0: return a == lo;
      2'h1: return a >= lo && a <= hi;
      2'h2: return a < lo || a > hi;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic fn_mask(input logic [15:0] v, m, d);
    return ((v ^ d) & ~m) == 16'h0;
  endfunction
  // act is {switch, trigger, routine, count, trace, break}
  function automatic logic [47:0] fn_stmt(input logic [7:0] en, req, input logic [5:0] act,
                                          input logic [1:0] g);
    return {22'h0, g, act, 2'b10, req, en};
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [71:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(input logic [1:0] g, input logic [3:0] sel, input logic [1:0] ix,
                     input logic [47:0] w);
    @(negedge mclk);
    {cfg_we, cfg_grp, cfg_sel, cfg_idx, cfg_wdata} = {1'b1, g, sel, ix, w};
    @(negedge mclk);
    cfg_we = 1'b0;
  endtask
  // staged values only go live on a run restart
  task automatic restart();
    @(negedge mclk);
    run_mode = 1'b0;
    repeat (5) @(negedge mclk);
    run_mode = 1'b1;
    repeat (6) @(negedge mclk);
  endtask
  // act is {break, trace, routine, trigger} seen one cycle after the sample
  task automatic cyc(input logic [23:0] a, input logic [15:0] d, s, p, input logic smp,
                     input logic [3:0] act);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    fork
      i_tgt.cycle(a, d, s, p, $urandom_range(3));
      begin
        while (!seen && n < 20) begin
          @(posedge mclk);
          #1;
          seen = (sample_ff === 1'b1);
          n++;
        end
        chk("sample", smp, seen);
        @(posedge mclk);
        #1;
        chk("actions", act, {break_req_ff, trace_we_ff, routine_req_ff, trigger_ff});
        if (act[2]) chk("trace record", {p, s, d, a}, trace_data_ff);
      end
    join
  endtask
  task automatic cya(input logic [23:0] a, input logic [3:0] act);
    cyc(a, rnd(), rnd(), rnd(), 1'b1, act);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [15:0] v, m, d;
    logic [23:0] lo, hi, a;
    logic        h;
    void'($urandom(32'hbe95));
    {arst_n, trace_capture_enable, run_mode, cfg_we} = 4'h4;
    clk_en = 1'b1;
    {cfg_grp, cfg_sel, cfg_idx, cfg_wdata} = '0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    chk("reset pulses", '0, {break_req_ff, trace_we_ff, routine_req_ff, trigger_ff, sample_ff});
    chk("reset state", '0, {active_grp_ff, event_count_ff, trace_data_ff[47:0]});
    // address modes at both range edges
    cfg(2'h0, `BCEM_SEL_STMT, 2'h0, fn_stmt(8'h01, 8'h01, 6'h03, 2'h0));
    for (int md = 0; md < 4; md++) begin
      lo = 24'h1000 + 24'(rnd());
      hi = lo + 24'h0000ff;
      cfg(2'h0, `BCEM_SEL_AC1, md[1:0], {hi, lo});
      restart();
      for (int k = 0; k < 4; k++) begin
        a = (k == 0) ? lo - 24'h1 : (k == 1) ? lo : (k == 2) ? hi : hi + 24'h1;
        h = fn_addr(md[1:0], lo, hi, a);
        cya(a, {h, h, 2'b00});
      end
    end
    // masked data, status and pod comparators
    for (int t = 2; t < 8; t += 2) begin
      v = rnd();
      m = rnd();
      cfg(2'h0, `BCEM_SEL_STMT, 2'h0, fn_stmt(8'h01 << t, 8'h01 << t, 6'h02, 2'h0));
      cfg(2'h0, t[3:0], 2'h0, {16'h0, m, v});
      restart();
      for (int k = 0; k < 4; k++) begin
        d = (v & ~m) | (rnd() & m);
        if (k[0]) d = d ^ rnd();
        h = fn_mask(v, m, d);
        cyc(24'(rnd()), t == 2 ? d : rnd(), t == 4 ? d : rnd(), t == 6 ? d : rnd(), 1'b1,
            {1'b0, h, 2'b00});
      end
    end
    // writes during a run stay staged
    cfg(2'h0, `BCEM_SEL_STMT, 2'h0, fn_stmt(8'h01, 8'h01, 6'h03, 2'h0));
    cfg(2'h0, `BCEM_SEL_AC1, 2'h0, 48'h1000);
    restart();
    cfg(2'h0, `BCEM_SEL_AC1, 2'h0, 48'h2000);
    cya(24'h001000, 4'hc);
    cya(24'h002000, 4'h0);
    restart();
    cya(24'h002000, 4'hc);
    // monitor switched off
    @(negedge mclk);
    trace_capture_enable = 1'b0;
    repeat (4) @(negedge mclk);
    cyc(24'h002000, rnd(), rnd(), rnd(), 1'b0, 4'h0);
    // a frozen clock enable lets a whole bus cycle pass unseen
    @(negedge mclk);
    {trace_capture_enable, clk_en} = 2'b10;
    cyc(24'h002000, rnd(), rnd(), rnd(), 1'b0, 4'h0);
    @(negedge mclk);
    clk_en = 1'b1;
    repeat (4) @(negedge mclk);
    cya(24'h002000, 4'hc);
    // or combine and an inverted term side by side
    cfg(2'h0, `BCEM_SEL_STMT, 2'h0, fn_stmt(8'h03, 8'h03, 6'h10, 2'h0) | 48'h10000);
    cfg(2'h0, `BCEM_SEL_STMT, 2'h1, fn_stmt(8'h03, 8'h01, 6'h01, 2'h0));
    restart();
    cya(24'h002000, 4'h9);
    cya(24'h003000, 4'h0);
    cfg(2'h0, `BCEM_SEL_STMT, 2'h1, 48'h0);
    // group switch, sequencing and occurrence limit
    cfg(2'h0, `BCEM_SEL_STMT, 2'h0, fn_stmt(8'h01, 8'h01, 6'h20, 2'h1));
    cfg(2'h1, `BCEM_SEL_AC1, 2'h0, 48'h4000);
    cfg(2'h1, `BCEM_SEL_AC2, 2'h0, 48'h5000);
    cfg(2'h1, `BCEM_SEL_CNT, 2'h0, 48'h2);
    cfg(2'h1, `BCEM_SEL_STMT, 2'h0, fn_stmt(8'h01, 8'h01, 6'h14, 2'h0));
    cfg(2'h1, `BCEM_SEL_STMT, 2'h1, fn_stmt(8'h82, 8'h82, 6'h08, 2'h0));
    restart();
    cya(24'h004000, 4'h0);
    cya(24'h002000, 4'h0);
    chk("group", 2'h1, active_grp_ff);
    cya(24'h004000, 4'h1);
    cya(24'h005000, 4'h0);
    cya(24'h002000, 4'h0);
    cya(24'h004000, 4'h1);
    chk("count", 16'h2, event_count_ff);
    cya(24'h005000, 4'h2);
    end_sim();
  end
endmodule // test_bus_cycle_event_monitor
